// ==== bench/tmpg_far_end.sv ====
// Purpose: far-end receiver paces slots and keeps bits
// Assumes: slot strobe high two cycles, low two
// Notes:   holds the last 32 bits seen, newest in bit 0
`timescale 1ns/1ps
`default_nettype none
module tmpg_far_end (
   input  wire logic        i_clk,
   input  wire logic        i_run,
   input  wire logic        i_bit,
   input  wire logic        i_vld,
   output logic             o_slot,
   output logic [31:0]      o_seen
);
   // ---
   // pacing and capture
   // ---
   logic [1:0] ph = 2'h0;
   initial o_slot = 1'b0;
   initial o_seen = 32'h0;
   // two low cycles keep the synchroniser gap legal
   always @(posedge i_clk) begin
      ph <= ph + 2'h1;
      o_slot <= #1 i_run & ph[1];
      if (i_vld) o_seen <= {o_seen[30:0], i_bit};
   end
endmodule // tmpg_far_end
`default_nettype wire

// ==== bench/tmpg_top_properties.sv ====
// Purpose: port-level properties of the mapping generator
// Assumes: one clock, asynchronous active-low reset
// Notes:   status outputs follow their inputs one edge later
`timescale 1ns/1ps
`default_nettype none
module tmpg_top_props (
   input wire logic        i_clk,
   input wire logic        i_rst_b,
   input wire logic [1:0]  i_structure,
   input wire logic [2:0]  i_payload,
   input wire logic [1:0]  i_group_sel,
   input wire logic        i_ext_sel,
   input wire logic [5:0]  i_lo_index,
   input wire logic [1:0]  i_ho_sel,
   input wire logic        i_edit_done,
   input wire logic        i_coupled,
   input wire logic        o_map_active_ff,
   input wire logic        o_cfg_error_ff,
   input wire logic        o_tx_bit_vld_ff,
   input wire logic        o_use_internal_ff,
   input wire logic [23:0] o_user_word_ff,
   input wire logic [1:0]  o_rx_structure_ff
);
   // ---
   // properties
   // ---
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   wire lo = i_structure == 2'h1;
   wire ho = i_structure == 2'h2;
   // a refused setting must never look active
   property p_refused(c);
      c |=> !o_map_active_ff && o_cfg_error_ff;
   endproperty
   AST_BULK_IDLE: assert property (i_structure == 2'h0 |=> !o_map_active_ff && !o_cfg_error_ff)
      else $error("bulk structure shows mapping");
   AST_LO_RATE: assert property (p_refused(lo && i_payload != 3'h1 && i_payload != 3'h2))
      else $error("low-order rate not refused");
   AST_HO_RATE: assert property (p_refused(ho && (i_payload == 3'h0 || i_payload >= 3'h6)))
      else $error("high-order rate not refused");
   AST_FULL_RATE: assert property (p_refused(i_structure == 2'h3 && i_payload inside {0, 7}))
      else $error("full container rate not refused");
   AST_LO_INDEX: assert property (p_refused(lo && i_group_sel != 2'h3 &&
                                  (i_lo_index == 6'h0 || i_lo_index > 6'h14)))
      else $error("bad tributary index not refused");
   AST_HO_POS: assert property (p_refused(ho && i_ho_sel == 2'h0))
      else $error("bad position not refused");
   AST_SOURCE: assert property (1'b1 |=> o_use_internal_ff != $past(i_ext_sel))
      else $error("source flag wrong");
   AST_COPY: assert property (i_coupled |=> o_rx_structure_ff == $past(i_structure))
      else $error("coupled copy wrong");
   AST_WORD_HOLD: assert property (!i_edit_done |=> $stable(o_user_word_ff))
      else $error("user word changed without done");
   AST_SLOT_PULSE: assert property (o_tx_bit_vld_ff |=> !o_tx_bit_vld_ff [*2])
      else $error("bit strobe too long");
   cover property (o_map_active_ff ##1 o_tx_bit_vld_ff);
   cover property (i_edit_done);
   cover property (i_coupled && o_map_active_ff);
endmodule // tmpg_top_props
bind tmpg_top tmpg_top_props chk (.*);
`default_nettype wire

// ==== bench/tmpg_top_tb_top.sv ====
// Purpose: self-checking bench for the mapping generator
// Assumes: settings move 1 ns after a rising edge
// Notes:   stream checks accept any phase of the pattern
`timescale 1ns/1ps
`default_nettype none
module tmpg_top_tb_top;
   logic i_clk, i_rst_b, i_ext_sel, i_ext_bit, i_bit_en, i_byte_wr, i_edit_done, i_coupled;
   logic o_map_active_ff, o_cfg_error_ff, o_tx_bit_ff, o_tx_bit_vld_ff, run;
   logic o_every_low_order_tributary_ff, o_use_internal_ff;
   logic [1:0] i_structure, i_group_sel, i_ho_sel, i_word_len, i_byte_preset;
   logic [1:0] o_tributary_group_ff, o_rx_structure_ff;
   logic [2:0] i_payload, i_pattern, i_byte_sel, o_rx_payload_ff, o_rx_pattern_ff;
   logic [5:0] i_lo_index, o_tributary_under_test_ff;
   logic [7:0] i_byte_val;
   logic [23:0] o_user_word_ff;
   logic [31:0] seen;
   int err_total = 0;
   int tests_run = 0;
   tmpg_top uut (.*);
   tmpg_far_end fe (.i_clk(i_clk), .i_run(run), .i_bit(o_tx_bit_ff),
      .i_vld(o_tx_bit_vld_ff), .o_slot(i_bit_en), .o_seen(seen));
   // ---
   // helpers
   // ---
   task chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s exp %h seen %h", nm, exp, got);
      end
   endtask
   task cfg(input logic [1:0] s, input logic [2:0] p, input logic [5:0] x,
            input logic [1:0] h, input logic a);
      @(posedge i_clk);
      #1 {i_structure, i_payload, i_lo_index, i_ho_sel} = {s, p, x, h};
      repeat (2) @(posedge i_clk);
      #1 chk("active", o_map_active_ff, a);
      chk("error", o_cfg_error_ff, s != 2'h0 && !a);
   endtask
   task edit(input logic [2:0] s, input logic [1:0] p, input logic [7:0] v, input logic d);
      @(posedge i_clk);
      #1 {i_byte_sel, i_byte_preset, i_byte_val, i_byte_wr, i_edit_done} = {s, p, v, 1'b1, d};
      @(posedge i_clk);
      #1 {i_byte_wr, i_edit_done} = 2'h0;
   endtask
   // true when the 32 bits seen are some phase of the word, msb first
   function automatic logic rot(input logic [23:0] w, input int n);
      logic f;
      logic m;
      f = 1'b0;
      for (int r = 0; r < n; r++) begin
         m = 1'b1;
         for (int j = 0; j < 32; j++)
            if (seen[31-j] !== w[n-1-((j+r)%n)]) m = 1'b0;
         f |= m;
      end
      return f;
   endfunction
   task close_out;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ---
   // clock, watchdog, tests
   // ---
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // about 900 cycles expected; allow more than three times that
   initial begin
      #30us;
      err_total++;
      close_out;
   end
   initial begin
      {i_structure, i_payload, i_ext_sel, i_ext_bit, i_pattern, i_group_sel, i_lo_index} = '0;
      {i_ho_sel, i_word_len, i_byte_sel, i_byte_preset, i_byte_wr, i_byte_val} = '0;
      {i_edit_done, i_coupled, run, i_rst_b} = '0;
      repeat (20) @(posedge i_clk);
      #1 i_rst_b = 1'b1;
      chk("word reset", o_user_word_ff, 24'haaaaaa);
      cfg(2'h0, 3'h2, 6'h01, 2'h1, 1'b0);
      cfg(2'h1, 3'h0, 6'h01, 2'h1, 1'b0);
      cfg(2'h1, 3'h4, 6'h01, 2'h1, 1'b0);
      cfg(2'h1, 3'h2, 6'h0d, 2'h1, 1'b1);
      chk("index", o_tributary_under_test_ff, 24'h0d);
      i_group_sel = 2'h3;
      cfg(2'h1, 3'h1, 6'h14, 2'h1, 1'b1);
      chk("every", o_every_low_order_tributary_ff, 1'b1);
      chk("group", o_tributary_group_ff, 2'h3);
      i_group_sel = 2'h0;
      cfg(2'h1, 3'h2, 6'h00, 2'h1, 1'b0);
      cfg(2'h1, 3'h2, 6'h15, 2'h1, 1'b0);
      cfg(2'h2, 3'h5, 6'h01, 2'h1, 1'b1);
      cfg(2'h2, 3'h6, 6'h01, 2'h1, 1'b0);
      cfg(2'h2, 3'h3, 6'h01, 2'h0, 1'b0);
      cfg(2'h3, 3'h6, 6'h01, 2'h1, 1'b1);
      cfg(2'h3, 3'h7, 6'h01, 2'h1, 1'b0);
      i_pattern = 3'h3;
      cfg(2'h3, 3'h1, 6'h01, 2'h1, 1'b0);
      $display("settings test done");
      cfg(2'h2, 3'h4, 6'h01, 2'h1, 1'b1);
      run = 1'b1;
      repeat (200) @(posedge i_clk);
      #1 chk("one in eight", rot(24'h80, 8), 1'b1);
      i_word_len = 2'h1;
      edit(3'h2, 2'h0, 8'h12, 1'b0);
      edit(3'h1, 2'h0, 8'h34, 1'b0);
      chk("word held", o_user_word_ff, 24'haaaaaa);
      edit(3'h0, 2'h0, 8'h00, 1'b1);
      chk("word edited", o_user_word_ff, 24'haa1234);
      i_pattern = 3'h4;
      repeat (200) @(posedge i_clk);
      #1 chk("user word", rot(24'h1234, 16), 1'b1);
      cfg(2'h2, 3'h1, 6'h01, 2'h1, 1'b0);
      cfg(2'h2, 3'h4, 6'h01, 2'h1, 1'b1);
      $display("pattern test done");
      edit(3'h4, 2'h1, 8'h5a, 1'b1);
      chk("preset zero", o_user_word_ff, 24'h001234);
      edit(3'h4, 2'h2, 8'h5a, 1'b1);
      chk("preset one", o_user_word_ff, 24'hff1234);
      edit(3'h4, 2'h3, 8'h5a, 1'b1);
      chk("preset default", o_user_word_ff, 24'haa1234);
      $display("word test done");
      {i_ext_sel, i_ext_bit, i_pattern} = {2'h3, 3'h1};
      repeat (200) @(posedge i_clk);
      #1 chk("external", seen[15:0], 16'hffff);
      chk("source", o_use_internal_ff, 1'b0);
      i_ext_sel = 1'b0;
      repeat (200) @(posedge i_clk);
      #1 chk("internal", seen[15:0], 16'h0000);
      i_coupled = 1'b1;
      repeat (2) @(posedge i_clk);
      #1 chk("rx structure", o_rx_structure_ff, 2'h2);
      chk("rx pattern", o_rx_pattern_ff, 3'h1);
      chk("rx payload", o_rx_payload_ff, 3'h4);
      $display("source test done");
      @(posedge i_clk);
      #1 i_rst_b = 1'b0;
      #1 chk("reset word", o_user_word_ff, 24'haaaaaa);
      chk("reset active", o_map_active_ff, 1'b0);
      repeat (2) @(posedge i_clk);
      #1 i_rst_b = 1'b1;
      repeat (2) @(posedge i_clk);
      #1 chk("active again", o_map_active_ff, 1'b1);
      $display("reset test done");
      close_out;
   end
endmodule // tmpg_top_tb_top
`default_nettype wire

// ==== pkg/tmpg_defines.vh ====
// Purpose: constants for the tributary mapping pattern generator
// Assumes: plain Verilog-2005, included by bare name
// Notes:   codes are one-hot or small enumerations chosen for this block
// Functional notes
// - tributary mapping acts only when structure is a tributary mapping mode
// - payload comes from external input or internal pattern source
// - floating modes need a tributary under test and payload before sending
// - low-order mode accepts only 2 Mb/s or 64k payloads
// - high-order mode accepts 34, 45, 8, 2 Mb/s or 64k payloads
// - full container mode accepts 140 Mb/s or any lower rate
// - low-order selection takes a group first: one of three, or all
// - low-order mode takes an index of one tributary within the group
// - high-order mode selects one of two positions, or all with code 3
// - selected pattern goes into tributary under test; offer depends on payload rate
// - one-mark-per-octet pattern sends 10000000 repeatedly
// - user word of 8, 16 or 24 bits for plesiochronous payloads only
// - user word bytes preset to zeros or ones, default 10101010
// - arbitrary user word bytes apply once editing is done
// - internal pattern applies only when payload is not external
// - coupled mode copies transmit settings to receive configuration
`ifndef TMPG_DEFINES_VH
`define TMPG_DEFINES_VH
// ---------------------------------------------------------------
// structure codes
// ---------------------------------------------------------------
`define TMPG_ST_BULK      2'h0
`define TMPG_ST_LO        2'h1
`define TMPG_ST_HO        2'h2
`define TMPG_ST_FULL      2'h3
// ---------------------------------------------------------------
// payload rate codes
// ---------------------------------------------------------------
`define TMPG_PL_NONE      3'h0
`define TMPG_PL_64K       3'h1
`define TMPG_PL_2M        3'h2
`define TMPG_PL_8M        3'h3
`define TMPG_PL_34M       3'h4
`define TMPG_PL_45M       3'h5
`define TMPG_PL_140M      3'h6
`define TMPG_PL_SYNC      3'h7
// ---------------------------------------------------------------
// pattern codes
// ---------------------------------------------------------------
`define TMPG_PAT_ONES     3'h0
`define TMPG_PAT_ZEROS    3'h1
`define TMPG_PAT_ALT      3'h2
`define TMPG_PAT_1IN8     3'h3
`define TMPG_PAT_USER     3'h4
`define TMPG_PAT_PRBS     3'h5
// ---------------------------------------------------------------
// word values and selections
// ---------------------------------------------------------------
`define TMPG_BYTE_1IN8    8'h80
`define TMPG_BYTE_DEF     8'haa
`define TMPG_BYTE_ZERO    8'h00
`define TMPG_BYTE_ONE     8'hff
`define TMPG_PRE_EDIT     2'h0
`define TMPG_PRE_ZERO     2'h1
`define TMPG_PRE_ONE      2'h2
`define TMPG_PRE_DEF      2'h3
`define TMPG_LEN_8        2'h0
`define TMPG_LEN_16       2'h1
`define TMPG_LEN_24       2'h2
`define TMPG_GRP_ALL      2'h3
`define TMPG_HO_ALL       2'h3
`define TMPG_LO_MAX       6'h14
`define TMPG_PRBS_SEED    15'h7fff
`endif

// ==== rtl/tmpg_top.v ====
// Purpose: tributary mapping and test pattern selection for transmit side
// Assumes: settings are quasi-static, from control software on i_clk
// Notes:   o_tx_bit_ff is the payload bit placed into the chosen tributary
`timescale 1ns/1ps
`default_nettype none
`include "tmpg_defines.vh"
module tmpg_top (
   input  wire        i_clk,
   input  wire        i_rst_b,
   input  wire [1:0]  i_structure,
   input  wire [2:0]  i_payload,
   input  wire        i_ext_sel,
   input  wire        i_ext_bit,
   input  wire        i_bit_en,
   input  wire [2:0]  i_pattern,
   input  wire [1:0]  i_group_sel,
   input  wire [5:0]  i_lo_index,
   input  wire [1:0]  i_ho_sel,
   input  wire [1:0]  i_word_len,
   input  wire [2:0]  i_byte_sel,
   input  wire [1:0]  i_byte_preset,
   input  wire        i_byte_wr,
   input  wire [7:0]  i_byte_val,
   input  wire        i_edit_done,
   input  wire        i_coupled,
   output reg         o_map_active_ff,
   output reg         o_cfg_error_ff,
   output reg         o_tx_bit_ff,
   output reg         o_tx_bit_vld_ff,
   output reg  [1:0]  o_tributary_group_ff,
   output reg  [5:0]  o_tributary_under_test_ff,
   output reg         o_every_low_order_tributary_ff,
   output reg         o_use_internal_ff,
   output reg  [23:0] o_user_word_ff,
   output reg  [1:0]  o_rx_structure_ff,
   output reg  [2:0]  o_rx_payload_ff,
   output reg  [2:0]  o_rx_pattern_ff
);
   // ------------------------------------------------------------
   // payload legality per structure
   // ------------------------------------------------------------
   function pl_ok;
      input [1:0] st;
      input [2:0] pl;
      begin
         case (st)
            `TMPG_ST_LO:   pl_ok = (pl == `TMPG_PL_2M) || (pl == `TMPG_PL_64K);
            `TMPG_ST_HO:   pl_ok = (pl >= `TMPG_PL_64K) && (pl <= `TMPG_PL_45M);
            `TMPG_ST_FULL: pl_ok = (pl >= `TMPG_PL_64K) && (pl <= `TMPG_PL_140M);
            default:       pl_ok = 1'b0;
         endcase
      end
   endfunction

   // pattern offered for given payload
   // 64k and synchronous payloads get no user word; a refused
   // pattern keeps the strobe quiet rather than send stale bits
   function pat_ok;
      input [2:0] pat;
      input [2:0] pl;
      begin
         case (pat)
            `TMPG_PAT_ONES, `TMPG_PAT_ZEROS, `TMPG_PAT_PRBS: pat_ok = 1'b1;
            `TMPG_PAT_ALT:  pat_ok = (pl != `TMPG_PL_SYNC);
            `TMPG_PAT_1IN8: pat_ok = (pl >= `TMPG_PL_2M) && (pl <= `TMPG_PL_140M);
            `TMPG_PAT_USER: pat_ok = (pl >= `TMPG_PL_2M) && (pl <= `TMPG_PL_140M);
            default:        pat_ok = 1'b0;
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // user word editing
   // ------------------------------------------------------------
   reg  [23:0] edit_ff;
   reg  [7:0]  pre_byte;
   reg  [23:0] nxt_edit;
   integer     k;

   // preset choice for the byte being set
   always @* begin
      case (i_byte_preset)
         `TMPG_PRE_ZERO: pre_byte = `TMPG_BYTE_ZERO;
         `TMPG_PRE_ONE:  pre_byte = `TMPG_BYTE_ONE;
         `TMPG_PRE_DEF:  pre_byte = `TMPG_BYTE_DEF;
         default:        pre_byte = i_byte_val;
      endcase
      nxt_edit = edit_ff;
      for (k = 0; k < 3; k = k + 1) begin
         if (i_byte_sel[k]) begin
            nxt_edit[k*8 +: 8] = pre_byte;
         end
      end
   end

   // default bytes; apply on done only
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         edit_ff        <= {3{`TMPG_BYTE_DEF}};
         o_user_word_ff <= {3{`TMPG_BYTE_DEF}};
      end else begin
         if (i_byte_wr) begin
            edit_ff <= nxt_edit;
         end
         if (i_edit_done) begin
            o_user_word_ff <= i_byte_wr ? nxt_edit : edit_ff;
         end
      end
   end

   // ------------------------------------------------------------
   // external input synchroniser
   // ------------------------------------------------------------
   reg [1:0] ext_sync_ff;
   reg [1:0] en_sync_ff;
   reg       en_last_ff;

   // only the second stage is read: the first may be metastable
   // a slot is lost if the strobe rises twice within two cycles
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ext_sync_ff <= 2'b00;
         en_sync_ff  <= 2'b00;
         en_last_ff  <= 1'b0;
      end else begin
         ext_sync_ff <= {ext_sync_ff[0], i_ext_bit};
         en_sync_ff  <= {en_sync_ff[0], i_bit_en};
         en_last_ff  <= en_sync_ff[1];
      end
   end
   // one pulse per payload bit slot, from the synced enable edge
   wire adv = en_sync_ff[1] & ~en_last_ff;

   // ------------------------------------------------------------
   // selection checks
   // ------------------------------------------------------------
   wire is_lo = (i_structure == `TMPG_ST_LO);
   wire is_ho = (i_structure == `TMPG_ST_HO);
   wire map_mode = (i_structure != `TMPG_ST_BULK);
   wire lo_sel_ok = (i_group_sel == `TMPG_GRP_ALL) ||
                    ((i_lo_index != 6'd0) && (i_lo_index <= `TMPG_LO_MAX));
   wire ho_sel_ok = (i_ho_sel != 2'd0);
   // floating modes need tributary and payload
   wire trib_ok = is_lo ? lo_sel_ok : (is_ho ? ho_sel_ok : 1'b1);
   wire pay_ok  = pl_ok(i_structure, i_payload);
   // pattern only used without external add
   wire pattern_ok = i_ext_sel || pat_ok(i_pattern, i_payload);
   wire all_ok = map_mode && trib_ok && pay_ok && pattern_ok;

   reg [2:0] pat_last_ff;
   wire      gen_bit;

   // any pattern change restarts the word at its first bit; the far end
   // first gets the bit held from the old pattern (twice if a slot meets the restart), then msb-first
   tmpg_word_gen u_gen (
      .i_clk     (i_clk),
      .i_rst_b   (i_rst_b),
      .i_adv     (adv),
      .i_restart (pat_last_ff != i_pattern),
      .i_pat     (i_pattern),
      .i_len     (i_word_len),
      .i_word    (o_user_word_ff),
      .o_bit_ff  (gen_bit)
   );

   // ------------------------------------------------------------
   // status, tributary and data outputs
   // ------------------------------------------------------------
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pat_last_ff                    <= `TMPG_PAT_ONES;
         o_map_active_ff                <= 1'b0;
         o_cfg_error_ff                 <= 1'b0;
         o_tx_bit_ff                    <= 1'b0;
         o_tx_bit_vld_ff                <= 1'b0;
         o_tributary_group_ff           <= 2'd0;
         o_tributary_under_test_ff      <= 6'd0;
         o_every_low_order_tributary_ff <= 1'b0;
         o_use_internal_ff              <= 1'b0;
      end else begin
         pat_last_ff     <= i_pattern;
         o_map_active_ff <= all_ok;
         o_cfg_error_ff  <= map_mode && !all_ok;
         // source select; internal when not external
         o_use_internal_ff <= !i_ext_sel;
         o_tx_bit_vld_ff <= adv && all_ok;
         if (adv) begin
            o_tx_bit_ff <= i_ext_sel ? ext_sync_ff[1] : gen_bit;
         end
         o_tributary_group_ff <= is_lo ? i_group_sel : 2'd0;
         o_every_low_order_tributary_ff <= is_lo && (i_group_sel == `TMPG_GRP_ALL);
         o_tributary_under_test_ff <= is_lo ? i_lo_index :
                                      (is_ho ? {4'd0, i_ho_sel} : 6'd0);
      end
   end

   // receive copy tracks only while coupled; it keeps the last
   // copied values once the two sides are made independent again
   // coupled copy to receive settings
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rx_structure_ff <= `TMPG_ST_BULK;
         o_rx_payload_ff   <= `TMPG_PL_NONE;
         o_rx_pattern_ff   <= `TMPG_PAT_ONES;
      end else if (i_coupled) begin
         o_rx_structure_ff <= i_structure;
         o_rx_payload_ff   <= i_payload;
         o_rx_pattern_ff   <= i_pattern;
      end
   end
endmodule // tmpg_top
`default_nettype wire

// ==== rtl/tmpg_word_gen.v ====
// Purpose: internal pattern bit source for the mapping generator
// Assumes: i_adv pulses once per payload bit slot
// Notes:   prbs is 2^15-1; pointer restarts on any pattern change
`timescale 1ns/1ps
`default_nettype none
`include "tmpg_defines.vh"
module tmpg_word_gen (
   input  wire        i_clk,
   input  wire        i_rst_b,
   input  wire        i_adv,
   input  wire        i_restart,
   input  wire [2:0]  i_pat,
   input  wire [1:0]  i_len,
   input  wire [23:0] i_word,
   output reg         o_bit_ff
);
   reg  [4:0]  ptr_ff;
   reg  [14:0] prbs_ff;
   reg  [4:0]  nxt_ptr;
   reg         nxt_bit;
   wire [4:0]  last_bit;
   wire [23:0] fix_word;

   // length of current word minus one
   assign last_bit = (i_pat == `TMPG_PAT_USER) ?
                     ((i_len == `TMPG_LEN_24) ? 5'd23 :
                      (i_len == `TMPG_LEN_16) ? 5'd15 : 5'd7) : 5'd7;
   // fixed patterns placed in the top byte; user word msb-first
   assign fix_word = (i_pat == `TMPG_PAT_USER) ?
                     ((i_len == `TMPG_LEN_24) ? i_word :
                      (i_len == `TMPG_LEN_16) ? {i_word[15:0], 8'h00} :
                      {i_word[7:0], 16'h0000}) :
                     (i_pat == `TMPG_PAT_1IN8) ? {`TMPG_BYTE_1IN8, 16'h0000} :
                     (i_pat == `TMPG_PAT_ALT) ? {`TMPG_BYTE_DEF, 16'h0000} :
                     (i_pat == `TMPG_PAT_ZEROS) ? 24'h000000 : 24'hffffff;

   always @* begin
      nxt_ptr = (ptr_ff >= last_bit) ? 5'd0 : ptr_ff + 5'd1;
      nxt_bit = (i_pat == `TMPG_PAT_PRBS) ? prbs_ff[14] :
                fix_word[5'd23 - ptr_ff];
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ptr_ff   <= 5'd0;
         prbs_ff  <= `TMPG_PRBS_SEED;
         o_bit_ff <= 1'b0;
      end else if (i_restart) begin
         ptr_ff   <= 5'd0;
      end else if (i_adv) begin
         ptr_ff   <= nxt_ptr;
         prbs_ff  <= {prbs_ff[13:0], prbs_ff[14] ^ prbs_ff[13]};
         o_bit_ff <= nxt_bit;
      end
   end
endmodule // tmpg_word_gen
`default_nettype wire
